/* hdl/prb_response_builder.v */
// Response packet builder for the programming agent
//
// What this block does
// - One response packet is sent for each command received.
// - Status opcode is four bits: 1 success, 2 failure, 3 unknown.
// - A command without error answers with the success status.
// - A non-query command with error answers failure, cause in the query/error byte.
// - An unrecognised command opcode answers with the unknown status.
// - Header: status 15:12, echo 11:8, byte 7:0; then length; then data.
// - The echo field carries the opcode actually processed.
// - One command outstanding; next command taken after the response ends.
// - Query commands return data in the byte, others an error code.
// - Both query commands always report success status.
// - Blank check returns F0 when blank, 0F otherwise.
// - Version query returns major nibble high, revision nibble low.
// - Successful non-query commands return error byte zero.
// - Failed verify of a write command returns error byte one.
// - Any other error returns error byte two.
// - Length counts all response words, both header words included.
// - All responses except the two reads are two words long.
// - Successful data read response length is the count plus two.
// - Successful program read length is three times half the rounded-up count, plus two.
// - Two read-only identification words are readable by data read.
// - Major revision field is six bits: 0 A, 1 B, 2 C.
// - Minor revision field holds the minor number in six binary bits.
`timescale 1ns/1ps
`include "prb_regs.vh"

module prb_response_builder
(
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [3:0] cmd_opcode,
  input wire [15:0] cmd_count,
  input wire [23:0] cmd_addr,
  input wire cmd_other_known,
  output wire exec_start,
  input wire res_valid,
  input wire res_verify_fail,
  input wire res_other_err,
  input wire res_blank,
  output wire dat_req,
  output wire [15:0] dat_index,
  input wire dat_valid,
  input wire [15:0] dat_word,
  output wire rsp_valid,
  output wire [15:0] rsp_data,
  output wire rsp_last,
  input wire rsp_ready,
  output wire busy
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_EXEC = 6'b00_0010;
  localparam [5:0] ST_HDR0 = 6'b00_0100;
  localparam [5:0] ST_HDR1 = 6'b00_1000;
  localparam [5:0] ST_FETCH = 6'b01_0000;
  localparam [5:0] ST_DATA = 6'b10_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Command classification

  function is_query;
    input [3:0] op;
    begin
      is_query = (op == `PRB_CMD_BLANK_CHECK) || (op == `PRB_CMD_VERSION);
    end
  endfunction

  function is_read;
    input [3:0] op;
    begin
      is_read = (op == `PRB_CMD_DATA_READ) || (op == `PRB_CMD_PROG_READ);
    end
  endfunction

  function is_write;
    input [3:0] op;
    begin
      is_write = (op == `PRB_CMD_DATA_WRITE) || (op == `PRB_CMD_PROG_WRITE) ||
        (op == `PRB_CMD_CONFIG_WRITE);
    end
  endfunction

  function [15:0] hdr_word;
    input [3:0] status;
    input [3:0] echo;
    input [7:0] qe;
    begin
      hdr_word = {status, echo, qe};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [5:0] state_ff;
  reg [5:0] nxt_state;
  reg [3:0] op_ff;
  reg [3:0] nxt_op;
  reg [15:0] count_ff;
  reg [15:0] nxt_count;
  reg [23:0] addr_ff;
  reg [23:0] nxt_addr;
  reg [15:0] len_ff;
  reg [15:0] nxt_len;
  reg [15:0] idx_ff;
  reg [15:0] nxt_idx;
  reg [15:0] word_ff;
  reg [15:0] nxt_word;
  reg exec_ff;
  reg nxt_exec;

  wire [15:0] full_len;
  wire [23:0] id_addr;
  wire id_hit;
  wire [15:0] id_word;
  wire use_id;
  wire recognised;
  wire [15:0] ndata;
  wire take_cmd;
  wire rsp_take;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  prb_len_calc u_len
  (
    .opcode(op_ff),
    .count(count_ff),
    .len(full_len)
  );

  assign id_addr = addr_ff + {7'h00, idx_ff, 1'b0};

  prb_id_region u_id
  (
    .addr(id_addr),
    .hit(id_hit),
    .word(id_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes

  assign recognised = is_query(cmd_opcode) || is_read(cmd_opcode) ||
    is_write(cmd_opcode) || cmd_other_known;
  assign cmd_ready = state_ff[0];
  assign take_cmd = cmd_valid && cmd_ready;
  assign rsp_valid = state_ff[2] || state_ff[3] || state_ff[5];
  assign rsp_take = rsp_valid && rsp_ready;
  assign rsp_data = word_ff;
  assign ndata = len_ff - `PRB_HDR_WORDS;
  assign rsp_last = (state_ff[3] && (ndata == 16'h0000)) ||
    (state_ff[5] && (idx_ff + 16'h0001 == ndata));
  assign use_id = (op_ff == `PRB_CMD_DATA_READ) && id_hit;
  assign dat_req = state_ff[4] && !use_id;
  assign dat_index = idx_ff;
  assign exec_start = exec_ff;
  assign busy = !state_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always @*
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_count = count_ff;
    nxt_addr = addr_ff;
    nxt_len = len_ff;
    nxt_idx = idx_ff;
    nxt_word = word_ff;
    nxt_exec = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (take_cmd)
        begin
          nxt_op = cmd_opcode;
          nxt_count = cmd_count;
          nxt_addr = cmd_addr;
          nxt_idx = 16'h0000;
          nxt_len = `PRB_HDR_WORDS;
          if (recognised)
          begin
            nxt_exec = 1'b1;
            nxt_state = ST_EXEC;
          end
          else
          begin
            nxt_word = hdr_word(`PRB_ST_UNKNOWN, cmd_opcode, `PRB_QE_UNKNOWN);
            nxt_state = ST_HDR0;
          end
        end
      end
      ST_EXEC:
      begin
        if (res_valid)
        begin
          nxt_state = ST_HDR0;
          if (op_ff == `PRB_CMD_BLANK_CHECK)
            nxt_word = hdr_word(`PRB_ST_PASS, op_ff,
              res_blank ? `PRB_QE_BLANK : `PRB_QE_NOT_BLANK);
          else if (op_ff == `PRB_CMD_VERSION)
            nxt_word = hdr_word(`PRB_ST_PASS, op_ff, `PRB_AGENT_VERSION);
          else if (res_verify_fail && is_write(op_ff))
            nxt_word = hdr_word(`PRB_ST_FAIL, op_ff, `PRB_QE_VERIFY_FAIL);
          else if (res_verify_fail || res_other_err)
            nxt_word = hdr_word(`PRB_ST_FAIL, op_ff, `PRB_QE_OTHER_ERROR);
          else
          begin
            nxt_word = hdr_word(`PRB_ST_PASS, op_ff, `PRB_QE_NO_ERROR);
            nxt_len = full_len;
          end
        end
      end
      ST_HDR0:
      begin
        if (rsp_take)
        begin
          nxt_word = len_ff;
          nxt_state = ST_HDR1;
        end
      end
      ST_HDR1:
      begin
        if (rsp_take)
        begin
          if (ndata == 16'h0000)
            nxt_state = ST_IDLE;
          else
            nxt_state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (use_id)
        begin
          nxt_word = id_word;
          nxt_state = ST_DATA;
        end
        else if (dat_valid)
        begin
          nxt_word = dat_word;
          nxt_state = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (rsp_take)
        begin
          nxt_idx = idx_ff + 16'h0001;
          if (rsp_last)
            nxt_state = ST_IDLE;
          else
            nxt_state = ST_FETCH;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      op_ff <= 4'h0;
      count_ff <= 16'h0000;
      addr_ff <= 24'h00_0000;
      len_ff <= 16'h0000;
      idx_ff <= 16'h0000;
      word_ff <= 16'h0000;
      exec_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      count_ff <= nxt_count;
      addr_ff <= nxt_addr;
      len_ff <= nxt_len;
      idx_ff <= nxt_idx;
      word_ff <= nxt_word;
      exec_ff <= nxt_exec;
    end
  end

endmodule // prb_response_builder

/* inc/prb_regs.vh */
// Constants for the programming response builder
`ifndef PRB_REGS_VH
`define PRB_REGS_VH

// Response status opcodes
`define PRB_ST_PASS 4'h1
`define PRB_ST_FAIL 4'h2
`define PRB_ST_UNKNOWN 4'h3

// Query and error byte values
`define PRB_QE_NO_ERROR 8'h00
`define PRB_QE_VERIFY_FAIL 8'h01
`define PRB_QE_OTHER_ERROR 8'h02
`define PRB_QE_BLANK 8'hf0
`define PRB_QE_NOT_BLANK 8'h0f
`define PRB_QE_UNKNOWN 8'h00

// Agent version reported by the version query (major nibble, revision nibble)
`define PRB_AGENT_VERSION 8'h10

// Command opcodes
`define PRB_CMD_BLANK_CHECK 4'ha
`define PRB_CMD_VERSION 4'hb
`define PRB_CMD_DATA_READ 4'h4
`define PRB_CMD_PROG_READ 4'h2
`define PRB_CMD_DATA_WRITE 4'h5
`define PRB_CMD_PROG_WRITE 4'h6
`define PRB_CMD_CONFIG_WRITE 4'h7

// First header word field positions
`define PRB_HDR_STATUS_MSB 15
`define PRB_HDR_STATUS_LSB 12
`define PRB_HDR_ECHO_MSB 11
`define PRB_HDR_ECHO_LSB 8
`define PRB_HDR_QE_MSB 7
`define PRB_HDR_QE_LSB 0

// Header size in words
`define PRB_HDR_WORDS 16'h0002

// Identification region byte addresses
`define PRB_ADDR_PART_ID 24'hff_0000
`define PRB_ADDR_SILICON_REV 24'hff_0002

// Revision word field positions
`define PRB_REV_PROC_MSB 15
`define PRB_REV_PROC_LSB 12
`define PRB_REV_MAJOR_MSB 11
`define PRB_REV_MAJOR_LSB 6
`define PRB_REV_MINOR_MSB 5
`define PRB_REV_MINOR_LSB 0

// Revision word values
`define PRB_REV_PROC_VALUE 4'h1
`define PRB_REV_MAJOR_A 6'h00
`define PRB_REV_MAJOR_B 6'h01
`define PRB_REV_MAJOR_C 6'h02

// Part identifier, arbitrary neutral value
`define PRB_PART_ID_VALUE 16'h5a5a
// Minor revision reset value
`define PRB_REV_MINOR_VALUE 6'h03

`endif

/* hdl/prb_id_region.v */
// Read-only two-word identification region
`timescale 1ns/1ps
`include "prb_regs.vh"

module prb_id_region
(
  input wire [23:0] addr,
  output reg hit,
  output reg [15:0] word
);

  wire [15:0] rev_word;

  assign rev_word = {`PRB_REV_PROC_VALUE, `PRB_REV_MAJOR_B, `PRB_REV_MINOR_VALUE};

  always @*
  begin
    hit = 1'b0;
    word = 16'h0000;
    if (addr == `PRB_ADDR_PART_ID)
    begin
      hit = 1'b1;
      word = `PRB_PART_ID_VALUE;
    end
    else if (addr == `PRB_ADDR_SILICON_REV)
    begin
      hit = 1'b1;
      word = rev_word;
    end
  end

endmodule // prb_id_region

/* hdl/prb_len_calc.v */
// Response length in words for a captured command
`timescale 1ns/1ps
`include "prb_regs.vh"

module prb_len_calc
(
  input wire [3:0] opcode,
  input wire [15:0] count,
  output reg [15:0] len
);

  reg [16:0] half_up;
  reg [18:0] packed_words;

  always @*
  begin
    half_up = ({1'b0, count} + 17'h0_0001) >> 1;
    packed_words = {2'b00, half_up} + {1'b0, half_up, 1'b0};
    if (opcode == `PRB_CMD_DATA_READ)
      len = count + `PRB_HDR_WORDS;
    else if (opcode == `PRB_CMD_PROG_READ)
      len = packed_words[15:0] + `PRB_HDR_WORDS;
    else
      len = `PRB_HDR_WORDS;
  end

endmodule // prb_len_calc

/* tb/prb_response_builder_asserts.sv */
// Port assertions for the response builder
`timescale 1ns/1ps
`include "prb_regs.vh"
module prb_checker
(
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [3:0] cmd_opcode,
  input wire cmd_other_known,
  input wire exec_start,
  input wire dat_req,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire rsp_last,
  input wire rsp_ready,
  input wire busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  wire known = cmd_other_known || (cmd_opcode inside {`PRB_CMD_BLANK_CHECK, `PRB_CMD_VERSION,
    `PRB_CMD_DATA_READ, `PRB_CMD_PROG_READ, `PRB_CMD_DATA_WRITE, `PRB_CMD_PROG_WRITE,
    `PRB_CMD_CONFIG_WRITE});
  ////////////////////////////////
  property p_idle; cmd_ready == !busy; endproperty
  a_idle: assert property (p_idle) else $error("ready not idle");
  property p_taken; take |=> !cmd_ready && busy; endproperty
  a_taken: assert property (p_taken) else $error("second command open");
  property p_start; take && known |=> exec_start && !rsp_valid; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_unknown_command_status;
    take && !known |=> rsp_valid && !exec_start && rsp_data == {4'h3, $past(cmd_opcode), 8'h00};
  endproperty
  a_unknown_command_status: assert property (p_unknown_command_status) else $error("bad unknown answer");
  property p_pulse; exec_start |=> !exec_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data); endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_end; rsp_valid && rsp_ready && rsp_last |=> cmd_ready; endproperty
  a_end: assert property (p_end) else $error("not idle after last");
  property p_fetch; dat_req |-> !rsp_valid && busy; endproperty
  a_fetch: assert property (p_fetch) else $error("word during fetch");
  c_start: cover property (take && known);
  c_unknown_command_status: cover property (take && !known);
  c_stall: cover property (rsp_valid && !rsp_ready);
  c_last: cover property (rsp_valid && rsp_ready && rsp_last);
endmodule // prb_checker
bind prb_response_builder prb_checker prb_checker_inst (.clk(clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
  .cmd_other_known(cmd_other_known), .exec_start(exec_start), .dat_req(dat_req),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
  .rsp_ready(rsp_ready), .busy(busy));

/* tb/prb_exec_model.sv */
// Executive and memory model behind the builder
`timescale 1ns/1ps
module prb_exec_model
(
  input wire clk,
  input wire exec_start,
  input wire dat_req,
  input wire [15:0] dat_index,
  input wire [3:0] lat,
  output reg res_valid,
  output reg dat_valid,
  output reg [15:0] dat_word
);
  initial
  begin
    res_valid = 1'b0;
    dat_valid = 1'b0;
    dat_word = 16'h0000;
  end
  ////////////////////////////////
  // One result pulse per started command
  always @(posedge clk)
  begin
    #1;
    if (exec_start === 1'b1)
    begin
      repeat (lat) @(posedge clk);
      #1 res_valid = 1'b1;
      @(posedge clk);
      #1 res_valid = 1'b0;
    end
  end
  // Released data lines show the inverted word
  always @(posedge clk)
  begin
    #1;
    if (dat_req === 1'b1)
    begin
      repeat (lat) @(posedge clk);
      #1 dat_word = 16'hc000 + dat_index;
      dat_valid = 1'b1;
      @(posedge clk);
      #1 dat_valid = 1'b0;
      dat_word = ~dat_word;
    end
  end
endmodule // prb_exec_model

/* tb/prb_response_builder_tb.sv */
// Self-checking bench for the response builder
`timescale 1ns/1ps
`include "prb_regs.vh"
`define CHK(n, e, g) chk(n, e, g)
module prb_response_builder_tb;
  reg clk, rst, cmd_valid, cmd_other_known, rsp_ready, slow;
  reg res_verify_fail, res_other_err, res_blank;
  reg [3:0] cmd_opcode, lat;
  reg [15:0] cmd_count;
  reg [23:0] cmd_addr;
  wire cmd_ready, exec_start, res_valid, dat_req, dat_valid, rsp_valid, rsp_last, busy;
  wire [15:0] dat_index, dat_word, rsp_data;
  reg [15:0] w [0:15];
  integer n, err_count, checked, starts, i;
  prb_response_builder prb_response_builder_inst (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_count(cmd_count), .cmd_addr(cmd_addr), .cmd_other_known(cmd_other_known),
    .exec_start(exec_start), .res_valid(res_valid), .res_verify_fail(res_verify_fail),
    .res_other_err(res_other_err), .res_blank(res_blank), .dat_req(dat_req),
    .dat_index(dat_index), .dat_valid(dat_valid), .dat_word(dat_word),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready), .busy(busy));
  prb_exec_model prb_exec_model_inst (.clk(clk), .exec_start(exec_start),
    .dat_req(dat_req), .dat_index(dat_index), .lat(lat), .res_valid(res_valid),
    .dat_valid(dat_valid), .dat_word(dat_word));
  ////////////////////////////////
  task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (err_count == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Issue one command, then collect its words until the last one
  task send(input [3:0] op, input [15:0] cnt, input [23:0] ad, input ok, input [2:0] q);
    integer t;
    reg done;
    begin
      {res_verify_fail, res_other_err, res_blank} = q;
      cmd_opcode = op;
      cmd_count = cnt;
      cmd_addr = ad;
      cmd_other_known = ok;
      cmd_valid = 1'b1;
      n = 0;
      t = 0;
      done = 1'b0;
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      while (!done && t < 300)
      begin
        @(negedge clk);
        t = t + 1;
        if (rsp_valid && rsp_ready)
        begin
          w[n] = rsp_data;
          n = n + 1;
          done = rsp_last;
        end
        @(posedge clk);
        #1 rsp_ready = !slow || !rsp_ready;
      end
      `CHK("done", 16'h0001, {15'h0000, done});
      `CHK("ready", 16'h0001, {15'h0000, cmd_ready});
    end
  endtask
  task hdr(input [15:0] e0, input [15:0] len);
    begin
      `CHK("word0", e0, w[0]);
      `CHK("length", len, w[1]);
      `CHK("words", len, n[15:0]);
    end
  endtask
  ////////////////////////////////
  task t_query;
    begin
      send(`PRB_CMD_BLANK_CHECK, 16'h0000, 24'h00_0000, 1'b0, 3'b001);
      hdr(16'h1af0, 16'h0002);
      send(`PRB_CMD_BLANK_CHECK, 16'h0000, 24'h00_0000, 1'b0, 3'b010);
      hdr(16'h1a0f, 16'h0002);
      send(`PRB_CMD_VERSION, 16'h0000, 24'h00_0000, 1'b0, 3'b100);
      hdr({8'h1b, `PRB_AGENT_VERSION}, 16'h0002);
    end
  endtask
  task t_write;
    reg [3:0] op;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        op = `PRB_CMD_DATA_WRITE + i[3:0];
        send(op, 16'h0000, 24'h00_0000, 1'b0, 3'b000);
        hdr({4'h1, op, 8'h00}, 16'h0002);
        send(op, 16'h0000, 24'h00_0000, 1'b0, 3'b100);
        hdr({4'h2, op, 8'h01}, 16'h0002);
        send(op, 16'h0000, 24'h00_0000, 1'b0, 3'b010);
        hdr({4'h2, op, 8'h02}, 16'h0002);
      end
    end
  endtask
  task t_other;
    integer s;
    begin
      send(4'h8, 16'h0000, 24'h00_0000, 1'b1, 3'b100);
      hdr(16'h2802, 16'h0002);
      s = starts;
      send(4'h0, 16'h0000, 24'h00_0000, 1'b0, 3'b000);
      hdr(16'h3000, 16'h0002);
      `CHK("starts", s[15:0], starts[15:0]);
    end
  endtask
  // Reset in mid-command drops it and leaves the idle values
  task t_reset;
    begin
      cmd_opcode = `PRB_CMD_DATA_WRITE;
      cmd_other_known = 1'b0;
      cmd_valid = 1'b1;
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      @(posedge clk);
      #1 rst = 1'b1;
      #1 `CHK("rbusy", 16'h0000, {15'h0000, busy});
      `CHK("rvalid", 16'h0000, {15'h0000, rsp_valid});
      `CHK("rdata", 16'h0000, rsp_data);
      `CHK("rstart", 16'h0000, {15'h0000, exec_start});
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk);
      #1 `CHK("rready", 16'h0001, {15'h0000, cmd_ready});
      `CHK("ridle", 16'h0000, {15'h0000, rsp_valid});
    end
  endtask
  task t_read;
    begin
      slow = 1'b1;
      send(`PRB_CMD_DATA_READ, 16'h0003, 24'h00_1000, 1'b0, 3'b000);
      hdr(16'h1400, 16'h0005);
      for (i = 0; i < 3; i = i + 1)
        `CHK("data", 16'hc000 + i[15:0], w[i + 2]);
      send(`PRB_CMD_PROG_READ, 16'h0003, 24'h00_1000, 1'b0, 3'b000);
      hdr(16'h1200, 16'h0008);
      send(`PRB_CMD_PROG_READ, 16'h0002, 24'h00_1000, 1'b0, 3'b000);
      hdr(16'h1200, 16'h0005);
      slow = 1'b0;
    end
  endtask
  task t_id;
    begin
      send(`PRB_CMD_DATA_READ, 16'h0002, 24'hff_0000, 1'b0, 3'b000);
      hdr(16'h1400, 16'h0004);
      `CHK("part", `PRB_PART_ID_VALUE, w[2]);
      `CHK("major", 16'h0001, {10'h000, w[3][11:6]});
      `CHK("minor", 16'h0003, {10'h000, w[3][5:0]});
      `CHK("proc", 16'h0001, {12'h000, w[3][15:12]});
    end
  endtask
  ////////////////////////////////
  always @(negedge clk)
    if (exec_start === 1'b1)
      starts = starts + 1;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_opcode = 4'h0;
    cmd_count = 16'h0000;
    cmd_addr = 24'h00_0000;
    cmd_other_known = 1'b0;
    {res_verify_fail, res_other_err, res_blank} = 3'b000;
    rsp_ready = 1'b1;
    slow = 1'b0;
    lat = 4'h1;
    err_count = 0;
    checked = 0;
    starts = 0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_query;
    t_write;
    lat = 4'h5;
    t_other;
    t_reset;
    t_read;
    t_id;
    report_and_stop;
  end
  initial
  begin
    #400000;
    err_count = err_count + 1;
    report_and_stop;
  end
endmodule // prb_response_builder_tb
